// ---- ubf_pkg.sv ----
// constants, codes and state encodings for the bridge serial port
package ubf_pkg;

  // ==========================================================
  // clocking and bit timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned REF_HI_MHZ = 24;
  localparam int unsigned REF_LO_MHZ = 16;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned MID_PHASE = OVERSAMPLE / 2 - 1;
  localparam int unsigned STOP_ONE = OVERSAMPLE;
  localparam int unsigned STOP_HALF = OVERSAMPLE * 3 / 2;
  localparam int unsigned STOP_TWO = OVERSAMPLE * 2;
  localparam int unsigned TOUT_CHARS = 4;
  localparam int unsigned BITS_PER_CHAR = 10;
  localparam int unsigned TOUT_TICKS = TOUT_CHARS * BITS_PER_CHAR * OVERSAMPLE;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [3:0] REG_DATA = 4'h0;
  localparam logic [3:0] REG_IEN = 4'h1;
  localparam logic [3:0] REG_IDQ = 4'h2;
  localparam logic [3:0] REG_LINE = 4'h3;
  localparam logic [3:0] REG_MODEM = 4'h4;
  localparam logic [3:0] REG_LSTAT = 4'h5;
  localparam logic [3:0] REG_MSTAT = 4'h6;
  localparam logic [3:0] REG_SCRATCH = 4'h7;
  localparam logic [3:0] REG_CLKSEL = 4'h8;
  localparam logic [3:0] REG_LAST = REG_CLKSEL;

  // ==========================================================
  // field positions
  localparam int unsigned LINE_DLAB = 7;
  localparam int unsigned LINE_BREAK = 6;
  localparam int unsigned LINE_STICK = 5;
  localparam int unsigned LINE_EVEN = 4;
  localparam int unsigned LINE_PEN = 3;
  localparam int unsigned LINE_STOP = 2;
  localparam int unsigned IEN_RDA = 0;
  localparam int unsigned IEN_THR = 1;
  localparam int unsigned IEN_LS = 2;
  localparam int unsigned QC_EN = 0;
  localparam int unsigned QC_RXCLR = 1;
  localparam int unsigned QC_TXCLR = 2;
  localparam int unsigned QC_TRIG = 6;

  // ==========================================================
  // interrupt identity codes and fill thresholds
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_LS = 4'h6;
  localparam logic [3:0] IID_RDA = 4'h4;
  localparam logic [3:0] IID_TOUT = 4'hc;
  localparam logic [3:0] IID_THR = 4'h2;
  localparam logic [4:0] TRIG_1 = 5'h01;
  localparam logic [4:0] TRIG_4 = 5'h04;
  localparam logic [4:0] TRIG_8 = 5'h08;
  localparam logic [4:0] TRIG_14 = 5'h0e;

  // ==========================================================
  // reset values and bus
  localparam logic [7:0] LINE_RST = 8'h03;
  localparam logic [7:0] DIVL_RST = 8'h01;
  localparam logic [7:0] DIVH_RST = 8'h00;
  localparam int unsigned AXI_DW = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } ubf_tx_e;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } ubf_rx_e;

endpackage

// ---- ubf_remote.sv ----
// remote serial device model on the two-pin link
`timescale 1ns/1ps
module ubf_remote #(
  parameter int BIT_NS = 1000
) (
  // link
  input wire logic txd,
  output logic rxd
);
  int nb = 8;
  logic pen = 1'b0;
  logic [8:0] got[$];
  initial rxd = 1'b1;
  // ==========================================================
  // frame into the port: start, data lsb first, parity, stop
  task automatic send(input logic [7:0] d, input logic p);
    rxd = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < nb; i++) begin
      rxd = d[i];
      #(BIT_NS);
    end
    if (pen) begin
      rxd = p;
      #(BIT_NS);
    end
    rxd = 1'b1;
    #(2 * BIT_NS);
  endtask
  // ==========================================================
  // mid-bit sampling of frames from the port
  always begin
    logic [8:0] v;
    @(negedge txd);
    v = '0;
    #(BIT_NS / 2);
    if (txd === 1'b0) begin
      for (int i = 0; i < nb; i++) begin
        #(BIT_NS);
        v[i] = txd;
      end
      if (pen) begin
        #(BIT_NS);
        v[8] = txd;
      end
      #(BIT_NS);
      got.push_back(v);
    end
  end
endmodule

// ---- ubf_uart.sv ----
// serial port with sixteen-entry queues behind an axi4-lite register slave
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module ubf_uart #(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock, reset, enable, strap
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic bridge_strap,
  // axi4-lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [ubf_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [ubf_pkg::AXI_DW/8-1:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [ubf_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // serial link and interrupt
  input wire logic rxd,
  output logic txd,
  output logic irq
);
  import ubf_pkg::*;

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] rdata;
    logic aw_ok, w_ok, wr_bad, wr_stb;
    logic [3:0] wr_idx;
    logic [7:0] wr_dat;
    logic strap, src16, fen;
    logic [1:0] trig;
    logic [7:0] dll, dlm, lcr, scr;
    logic [4:0] mcr;
    logic [3:0] ier;
    logic [8:0] acc;
    logic [15:0] div_cnt;
    logic tick;
    logic s1, s2, s3, rx_lvl, filt, filt_cnt;
    logic [DEPTH-1:0][7:0] txm;
    logic [DEPTH-1:0][7:0] rxm;
    logic [PW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [PW:0] tx_cnt, rx_cnt;
    ubf_tx_e tst;
    logic [7:0] tsh;
    logic tpar, tline, txd;
    logic [2:0] tbit;
    logic [5:0] tph;
    ubf_rx_e rxst;
    logic [7:0] rsh;
    logic [2:0] rbit;
    logic [3:0] rph;
    logic rpar;
    logic oe, pe, fe, bi, thre_pend;
    logic [9:0] tout;
    logic irq;
  } ubf_state_s;

  ubf_state_s q;
  ubf_state_s n;
  logic tx_push, tx_pop, rx_push, rx_pop, tx_clr, rx_clr;
  logic [PW:0] cap;
  logic [15:0] div_eff;
  logic [2:0] last_bit;
  logic [5:0] stop_len;
  logic [4:0] dec;

  // ==========================================================
  // helpers
  function automatic logic [4:0] f_dec(input logic [ADDR_W-1:0] a);
    logic bad;
    bad = (a[ADDR_W-1:6] != '0) || (a[5:2] > REG_LAST);
    return {bad, a[5:2]};
  endfunction

  function automatic logic f_par(input logic [7:0] d, input logic [7:0] lcr);
    logic [7:0] mask;
    logic x;
    mask = 8'hff >> (2'h3 - lcr[1:0]);
    x = ^(d & mask);
    if (lcr[LINE_STICK]) begin
      return !lcr[LINE_EVEN];
    end
    return lcr[LINE_EVEN] ? x : !x;
  endfunction

  function automatic logic [4:0] f_trig(input logic [1:0] t);
    case (t)
      2'h0: return TRIG_1;
      2'h1: return TRIG_4;
      2'h2: return TRIG_8;
      default: return TRIG_14;
    endcase
  endfunction

  function automatic logic [3:0] f_iid(input ubf_state_s s);
    logic rda;
    rda = s.fen ? (5'(s.rx_cnt) >= f_trig(s.trig)) : (s.rx_cnt != '0);
    if (s.ier[IEN_LS] && (s.oe || s.pe || s.fe || s.bi)) begin
      return IID_LS;
    end else if (s.ier[IEN_RDA] && rda) begin
      return IID_RDA;
    end else if (s.ier[IEN_RDA] && s.fen && s.tout == 10'(TOUT_TICKS)) begin
      return IID_TOUT;
    end else if (s.ier[IEN_THR] && s.thre_pend) begin
      return IID_THR;
    end
    return IID_NONE;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    n = q;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tx_clr = 1'b0;
    rx_clr = 1'b0;
    cap = q.fen ? (PW+1)'(DEPTH) : (PW+1)'(1);
    div_eff = ({q.dlm, q.dll} == 16'h0) ? 16'h1 : {q.dlm, q.dll};
    // index of the last data bit is four plus the length code
    last_bit = {1'b1, q.lcr[1:0]};
    stop_len = !q.lcr[LINE_STOP] ? 6'(STOP_ONE) :
               (q.lcr[1:0] == 2'h0) ? 6'(STOP_HALF) : 6'(STOP_TWO);
    dec = 5'h0;
    if (!aresetn) begin
      n = '0;
      n.strap = bridge_strap;
      n.awready = 1'b1;
      n.wready = 1'b1;
      n.arready = 1'b1;
      n.lcr = LINE_RST;
      n.dll = DIVL_RST;
      n.dlm = DIVH_RST;
      n.s1 = 1'b1;
      n.s2 = 1'b1;
      n.s3 = 1'b1;
      n.rx_lvl = 1'b1;
      n.filt = 1'b1;
      n.tline = 1'b1;
      n.txd = 1'b1;
      n.tst = TX_IDLE;
      n.rxst = RX_IDLE;
    end else if (clk_en) begin
      // reference tick at 24 or 16 MHz, then divisor to the x16 bit clock
      n.acc = q.acc + (q.src16 ? 9'(REF_LO_MHZ) : 9'(REF_HI_MHZ));
      n.tick = 1'b0;
      if (n.acc >= 9'(CLK_MHZ)) begin
        n.acc = n.acc - 9'(CLK_MHZ);
        if (q.div_cnt >= div_eff - 16'h1) begin
          n.div_cnt = 16'h0;
          n.tick = 1'b1;
        end else begin
          n.div_cnt = q.div_cnt + 16'h1;
        end
      end
      // line synchroniser and spike filter
      n.s1 = rxd;
      n.s2 = q.s1;
      n.s3 = q.s2;
      if (q.s2 == q.s3) begin
        n.rx_lvl = q.s3;
      end
      if (q.tick) begin
        if (q.rx_lvl == q.filt) begin
          n.filt_cnt = 1'b0;
        end else if (q.filt_cnt) begin
          n.filt = q.rx_lvl;
          n.filt_cnt = 1'b0;
        end else begin
          n.filt_cnt = 1'b1;
        end
      end
      // bus write
      if (s_axi_awvalid && q.awready) begin
        dec = f_dec(s_axi_awaddr);
        n.aw_ok = 1'b1;
        n.awready = 1'b0;
        n.wr_bad = dec[4];
        n.wr_idx = dec[3:0];
      end
      if (s_axi_wvalid && q.wready) begin
        n.w_ok = 1'b1;
        n.wready = 1'b0;
        n.wr_dat = s_axi_wdata[7:0];
        n.wr_stb = s_axi_wstrb[0];
      end
      if (q.aw_ok && q.w_ok && !q.bvalid) begin
        n.aw_ok = 1'b0;
        n.w_ok = 1'b0;
        n.bvalid = 1'b1;
        n.bresp = q.wr_bad ? RESP_SLVERR : RESP_OKAY;
        if (!q.wr_bad && q.wr_stb) begin
          case (q.wr_idx)
            REG_DATA: begin
              if (q.lcr[LINE_DLAB]) begin
                n.dll = q.wr_dat;
              end else if (q.tx_cnt < cap) begin
                tx_push = 1'b1;
                n.thre_pend = 1'b0;
              end
            end
            REG_IEN: begin
              if (q.lcr[LINE_DLAB]) begin
                n.dlm = q.wr_dat;
              end else begin
                n.ier = q.wr_dat[3:0];
                if (q.wr_dat[IEN_THR] && !q.ier[IEN_THR] && q.tx_cnt == '0) begin
                  n.thre_pend = 1'b1;
                end
              end
            end
            REG_IDQ: begin
              n.fen = q.wr_dat[QC_EN];
              n.trig = q.wr_dat[QC_TRIG +: 2];
              rx_clr = q.wr_dat[QC_RXCLR] || (q.wr_dat[QC_EN] != q.fen);
              tx_clr = q.wr_dat[QC_TXCLR] || (q.wr_dat[QC_EN] != q.fen);
            end
            REG_LINE: n.lcr = q.wr_dat;
            REG_MODEM: n.mcr = q.wr_dat[4:0];
            REG_SCRATCH: n.scr = q.wr_dat;
            REG_CLKSEL: n.src16 = q.wr_dat[0];
            default: n.scr = q.scr;
          endcase
        end
      end
      if (q.bvalid && s_axi_bready) begin
        n.bvalid = 1'b0;
        n.awready = 1'b1;
        n.wready = 1'b1;
      end
      // bus read, with its side effects on the receive queue and flags
      if (s_axi_arvalid && q.arready) begin
        dec = f_dec(s_axi_araddr);
        n.arready = 1'b0;
        n.rvalid = 1'b1;
        n.rresp = dec[4] ? RESP_SLVERR : RESP_OKAY;
        n.rdata = 8'h0;
        if (!dec[4]) begin
          case (dec[3:0])
            REG_DATA: begin
              if (q.lcr[LINE_DLAB]) begin
                n.rdata = q.dll;
              end else begin
                n.rdata = q.rxm[q.rx_rp];
                rx_pop = (q.rx_cnt != '0);
              end
            end
            REG_IEN: n.rdata = q.lcr[LINE_DLAB] ? q.dlm : {4'h0, q.ier};
            REG_IDQ: begin
              n.rdata = {q.fen, q.fen, 2'h0, f_iid(q)};
              if (f_iid(q) == IID_THR) begin
                n.thre_pend = 1'b0;
              end
            end
            REG_LINE: n.rdata = q.lcr;
            REG_MODEM: n.rdata = {3'h0, q.mcr};
            REG_LSTAT: begin
              n.rdata = {q.fen && (q.pe || q.fe || q.bi),
                         q.tx_cnt == '0 && q.tst == TX_IDLE, q.tx_cnt == '0,
                         q.bi, q.fe, q.pe, q.oe, q.rx_cnt != '0};
              n.oe = 1'b0;
              n.pe = 1'b0;
              n.fe = 1'b0;
              n.bi = 1'b0;
            end
            REG_SCRATCH: n.rdata = q.scr;
            REG_CLKSEL: n.rdata = {6'h0, q.strap, q.src16};
            default: n.rdata = 8'h0;
          endcase
        end
      end
      if (q.rvalid && s_axi_rready) begin
        n.rvalid = 1'b0;
        n.arready = 1'b1;
      end
      // transmitter: one bit every sixteen ticks
      if (q.tick && q.strap) begin
        case (q.tst)
          TX_IDLE: begin
            if (q.tx_cnt != '0) begin
              tx_pop = 1'b1;
              n.tsh = q.txm[q.tx_rp];
              n.tpar = f_par(q.txm[q.tx_rp], q.lcr);
              n.tst = TX_START;
              n.tph = 6'h0;
              n.tline = 1'b0;
            end
          end
          TX_START: begin
            n.tph = q.tph + 6'h1;
            if (q.tph == 6'(OVERSAMPLE - 1)) begin
              n.tph = 6'h0;
              n.tst = TX_DATA;
              n.tbit = 3'h0;
              n.tline = q.tsh[0];
            end
          end
          TX_DATA: begin
            n.tph = q.tph + 6'h1;
            if (q.tph == 6'(OVERSAMPLE - 1)) begin
              n.tph = 6'h0;
              if (q.tbit == last_bit) begin
                n.tst = q.lcr[LINE_PEN] ? TX_PAR : TX_STOP;
                n.tline = q.lcr[LINE_PEN] ? q.tpar : 1'b1;
              end else begin
                n.tbit = q.tbit + 3'h1;
                n.tsh = q.tsh >> 1;
                n.tline = q.tsh[1];
              end
            end
          end
          TX_PAR: begin
            n.tph = q.tph + 6'h1;
            if (q.tph == 6'(OVERSAMPLE - 1)) begin
              n.tph = 6'h0;
              n.tst = TX_STOP;
              n.tline = 1'b1;
            end
          end
          TX_STOP: begin
            n.tph = q.tph + 6'h1;
            if (q.tph == stop_len - 6'h1) begin
              n.tph = 6'h0;
              n.tst = TX_IDLE;
            end
          end
          default: n.tst = TX_IDLE;
        endcase
      end
      n.txd = n.tline && !n.lcr[LINE_BREAK];
      // receiver: centre of each bit sampled from the filtered line
      if (q.tick && q.strap) begin
        case (q.rxst)
          RX_IDLE: begin
            if (!q.filt) begin
              n.rxst = RX_START;
              n.rph = 4'h0;
              n.rsh = 8'h0;
            end
          end
          RX_START: begin
            n.rph = q.rph + 4'h1;
            if (q.rph == 4'(MID_PHASE)) begin
              n.rph = 4'h0;
              n.rbit = 3'h0;
              n.rxst = q.filt ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            n.rph = q.rph + 4'h1;
            if (q.rph == 4'(OVERSAMPLE - 1)) begin
              n.rph = 4'h0;
              n.rsh[q.rbit] = q.filt;
              n.rbit = q.rbit + 3'h1;
              if (q.rbit == last_bit) begin
                n.rxst = q.lcr[LINE_PEN] ? RX_PAR : RX_STOP;
              end
            end
          end
          RX_PAR: begin
            n.rph = q.rph + 4'h1;
            if (q.rph == 4'(OVERSAMPLE - 1)) begin
              n.rph = 4'h0;
              n.rpar = q.filt;
              n.rxst = RX_STOP;
            end
          end
          RX_STOP: begin
            n.rph = q.rph + 4'h1;
            if (q.rph == 4'(OVERSAMPLE - 1)) begin
              n.rph = 4'h0;
              n.rxst = RX_IDLE;
              // error sets follow the status-read clears so a new event wins
              if (q.lcr[LINE_PEN] && (q.rpar != f_par(q.rsh, q.lcr))) begin
                n.pe = 1'b1;
              end
              if (!q.filt) begin
                n.fe = 1'b1;
              end
              if (q.rsh == 8'h0 && !q.filt && !(q.lcr[LINE_PEN] && q.rpar)) begin
                n.bi = 1'b1;
              end
              if (q.rx_cnt < cap || rx_pop) begin
                rx_push = 1'b1;
              end else begin
                n.oe = 1'b1;
              end
            end
          end
          default: n.rxst = RX_IDLE;
        endcase
      end
      // queue bookkeeping
      if (tx_push) begin
        n.txm[q.tx_wp] = q.wr_dat;
        n.tx_wp = q.tx_wp + PW'(1);
      end
      if (tx_pop) begin
        n.tx_rp = q.tx_rp + PW'(1);
        if (q.tx_cnt == (PW+1)'(1) && !tx_push) begin
          n.thre_pend = 1'b1;
        end
      end
      n.tx_cnt = q.tx_cnt + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
      if (rx_push) begin
        n.rxm[q.rx_wp] = q.rsh;
        n.rx_wp = q.rx_wp + PW'(1);
      end
      if (rx_pop) begin
        n.rx_rp = q.rx_rp + PW'(1);
      end
      n.rx_cnt = q.rx_cnt + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
      if (tx_clr) begin
        n.tx_wp = '0;
        n.tx_rp = '0;
        n.tx_cnt = '0;
      end
      if (rx_clr) begin
        n.rx_wp = '0;
        n.rx_rp = '0;
        n.rx_cnt = '0;
      end
      // character timeout counts ticks while data waits unread
      if (rx_push || rx_pop || n.rx_cnt == '0) begin
        n.tout = 10'h0;
      end else if (q.tick && q.tout != 10'(TOUT_TICKS)) begin
        n.tout = q.tout + 10'h1;
      end
      n.irq = (f_iid(n) != IID_NONE);
    end
  end

  always_ff @(posedge aclk) begin
    q <= n;
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = {24'h0, q.rdata};
  assign txd = q.txd;
  assign irq = q.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_both_held;
    q.aw_ok && q.w_ok && !q.bvalid && clk_en;
  endsequence

  a_write_resp: assert property (s_both_held |=> q.bvalid)
    else $error("write response missing");
  a_read_resp: assert property (s_axi_arvalid && q.arready && clk_en |=> q.rvalid && !q.arready)
    else $error("read response missing");
  a_tx_start_low: assert property (q.tst == TX_START && !q.lcr[LINE_BREAK] |-> !q.txd)
    else $error("start bit not low");
  a_tx_phase_cap: assert property (q.tst != TX_STOP |-> q.tph < 6'(OVERSAMPLE))
    else $error("bit phase beyond sixteen");
  a_stop_len: assert property (q.tst == TX_STOP |-> q.tph < stop_len)
    else $error("stop phase beyond length");
  a_strap_quiet: assert property (!q.strap |-> q.tst == TX_IDLE && q.rxst == RX_IDLE)
    else $error("port active without strap");
  a_rx_queue_cap: assert property (q.rx_cnt <= (PW+1)'(DEPTH) && (!q.fen -> q.rx_cnt <= 1))
    else $error("receive queue overfilled");
  a_tx_queue_cap: assert property (q.tx_cnt <= (PW+1)'(DEPTH))
    else $error("transmit queue overfilled");
  a_ls_first: assert property (q.ier[IEN_LS] && (q.pe || q.fe || q.bi || q.oe) |-> f_iid(q) == IID_LS)
    else $error("line status not highest priority");
  a_irq_follows: assert property (clk_en && f_iid(n) != IID_NONE |=> q.irq)
    else $error("interrupt line not raised");
  a_tx_empty_pend: assert property (clk_en && tx_pop && !tx_push && q.tx_cnt == 1 |=> q.thre_pend)
    else $error("transmit empty not flagged");
  a_filter_hold: assert property (clk_en && q.tick && q.rx_lvl != q.filt && !q.filt_cnt |=> $stable(q.filt))
    else $error("filter took a one-tick spike");

endmodule

// ---- ubf_uart_test.sv ----
// self-checking bench for the bridge serial port
`timescale 1ns/1ps
module ubf_uart_test;
  import ubf_pkg::*;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
  logic aclk = 0, aresetn = 0, strap = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd, irq;
  logic [1:0] bresp, rresp;
  int bad_count = 0, checks_done = 0;
  always #2 aclk = ~aclk;
  ubf_uart dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .bridge_strap(strap),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .rxd(rxd), .txd(txd), .irq(irq));
  ubf_remote rem_u (.txd(txd), .rxd(rxd));
  // ==========================================================
  // bus tasks
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic a, w;
    a = 0;
    w = 0;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h0, d};
    bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        a = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    `CHK(bresp, (i > REG_LAST) ? RESP_SLVERR : RESP_OKAY)
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, output logic [7:0] d, output logic [1:0] r);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= {2'b00, i, 2'b00};
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    `CHK(rdata[31:8], 24'h0)
    rready <= 1'b0;
  endtask
  task automatic get_frame(output logic [8:0] g);
    g = 'x;
    for (int t = 0; t < 5000 && rem_u.got.size() == 0; t++) @(posedge aclk);
    if (rem_u.got.size() > 0) g = rem_u.got.pop_front();
  endtask
  function automatic logic exp_par(logic [7:0] d, logic [7:0] f);
    if (f[5]) return ~f[4];
    return f[4] ? ^d : ~^d;
  endfunction
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge aclk);
    bad_count++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] d, b, m, fmt;
    logic [1:0] r;
    logic [7:0] fmts [5];
    int n;
    logic [8:0] g;
    logic [7:0] bs [4];
    fmts = '{8'h03, 8'h1b, 8'h0a, 8'h2b, 8'h04};
    void'($urandom(44343));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(REG_LINE, d, r);
    `CHK(d, LINE_RST)
    rd(4'h9, d, r);
    `CHK(r, RESP_SLVERR)
    wr(4'h9, 8'h00);
    wr(REG_CLKSEL, 8'h01);
    wr(REG_LINE, 8'h80);
    wr(REG_DATA, DIVL_RST);
    foreach (fmts[k]) begin
      fmt = fmts[k];
      n = 5 + fmt[1:0];
      m = 8'hff >> (8 - n);
      rem_u.nb = n;
      rem_u.pen = fmt[3];
      wr(REG_LINE, fmt);
      wr(REG_IEN, 8'h05);
      b = 8'($urandom) & m;
      wr(REG_DATA, b);
      get_frame(g);
      `CHK(g, {fmt[3] & exp_par(b, fmt), b})
      b = 8'($urandom) & m;
      rem_u.send(b, exp_par(b, fmt) ^ (k == 1));
      rd(REG_IDQ, d, r);
      `CHK(d[3:0], (k == 1) ? IID_LS : IID_RDA)
      `CHK(irq, 1'b1)
      rd(REG_LSTAT, d, r);
      `CHK(d[2], k == 1)
      rd(REG_DATA, d, r);
      `CHK(d, b)
    end
    // queued transmit of three bytes, then transmit-empty report
    rem_u.nb = 8;
    rem_u.pen = 1'b0;
    wr(REG_LINE, 8'h03);
    wr(REG_IDQ, 8'h41);
    wr(REG_IEN, 8'h03);
    foreach (bs[j]) bs[j] = 8'($urandom);
    for (int j = 0; j < 3; j++) wr(REG_DATA, bs[j]);
    for (int j = 0; j < 3; j++) begin
      get_frame(g);
      `CHK(g, {1'b0, bs[j]})
    end
    `CHK(irq, 1'b1)
    rd(REG_IDQ, d, r);
    `CHK(d, {2'b11, 2'b00, IID_THR})
    // receive threshold of four and character timeout
    for (int j = 0; j < 3; j++) rem_u.send(bs[j], 1'b0);
    rd(REG_IDQ, d, r);
    `CHK(d[3:0], IID_NONE)
    repeat (11000) @(posedge aclk);
    rd(REG_IDQ, d, r);
    `CHK(d[3:0], IID_TOUT)
    `CHK(irq, 1'b1)
    rem_u.send(bs[3], 1'b0);
    rd(REG_IDQ, d, r);
    `CHK(d[3:0], IID_RDA)
    `CHK(irq, 1'b1)
    foreach (bs[j]) begin
      rd(REG_DATA, d, r);
      `CHK(d, bs[j])
    end
    // strap low at a second reset keeps the port silent
    aresetn <= 1'b0;
    strap <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    wr(REG_DATA, 8'h5a);
    repeat (3000) @(posedge aclk);
    `CHK(rem_u.got.size(), 0)
    rd(REG_LSTAT, d, r);
    `CHK(d[6:5], 2'b00)
    rd(REG_CLKSEL, d, r);
    `CHK(d[1:0], 2'b00)
    finish_test();
  end
endmodule
